/* File: verilog/gjc_codec.v */
// Purpose: justification count encoder and decoder with AXI4-Lite registers
// Assumes: one frame strobe per frame on each side, same clock
// Notes:   14-bit count coding; 10-bit mode is reported only
`timescale 1ns/1ns
`include "gjc_codec_regs.vh"

module gjc_codec #(
    parameter ADDR_W = 8
) (
    // clock and reset
    input  wire              mclk,
    input  wire              arst_n,
    // register bus
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // mapper side
    input  wire              txFrameStb,
    input  wire [13:0]       txCount,
    output reg  [7:0]        txCountOverheadFirstByte,
    output reg  [7:0]        txCountOverheadSecondByte,
    output reg  [7:0]        txCountCrcByte,
    output reg               txOverheadValid,
    // demapper side
    input  wire              rxFrameStb,
    input  wire [7:0]        rxCountOverheadFirstByte,
    input  wire [7:0]        rxCountOverheadSecondByte,
    input  wire [7:0]        rxCountCrcByte,
    output reg  [13:0]       rxCount,
    output reg               rxCountValid,
    output reg               rxSync,
    output reg               rxCrcErr
);

// ----------------------------------------
// encodings
// ----------------------------------------
localparam OP_Z    = 3'd0;
localparam OP_P1   = 3'd1;
localparam OP_M1   = 3'd2;
localparam OP_P2   = 3'd3;
localparam OP_M2   = 3'd4;
localparam OP_BIG  = 3'd5;
localparam OP_NONE = 3'd7;

localparam ST_HUNT = 3'b001;
localparam ST_PEND = 3'b010;
localparam ST_SYNC = 3'b100;

// ----------------------------------------
// functions
// ----------------------------------------
// remainder of 24 bits modulo the generator
function [7:0] crcRem24;
    input [23:0] d;
    integer      i;
    reg   [7:0]  r;
    begin
        r = 8'h00;
        for (i = 23; i >= 0; i = i - 1) begin
            r = r[7] ? ({r[6:0], d[i]} ^ `GJC_CRC_POLY) : {r[6:0], d[i]};
        end
        crcRem24 = r;
    end
endfunction

// {mask, incrementIndicator, decrementIndicator}
function [15:0] patOf;
    input [2:0] op;
    begin
        case (op)
            OP_Z:    patOf = 16'h0000;
            OP_P1:   patOf = {`GJC_MASK_P1, 2'b10};
            OP_M1:   patOf = {`GJC_MASK_M1, 2'b01};
            OP_P2:   patOf = {`GJC_MASK_P2, 2'b10};
            OP_M2:   patOf = {`GJC_MASK_M2, 2'b01};
            default: patOf = 16'h0003;
        endcase
    end
endfunction

function [13:0] maskOf;
    input [2:0]  op;
    reg   [15:0] t;
    begin
        t      = patOf(op);
        maskOf = t[15:2];
    end
endfunction

function [13:0] stepOf;
    input [2:0] op;
    begin
        case (op)
            OP_P1:   stepOf = 14'h0001;
            OP_M1:   stepOf = 14'h3fff;
            OP_P2:   stepOf = 14'h0002;
            OP_M2:   stepOf = 14'h3ffe;
            default: stepOf = 14'h0000;
        endcase
    end
endfunction

// one of the two steps that an indicator pair allows
function [2:0] candOp;
    input inc;
    input idx;
    begin
        if (inc) begin
            candOp = idx ? OP_P2 : OP_P1;
        end else begin
            candOp = idx ? OP_M2 : OP_M1;
        end
    end
endfunction

// op whose pattern one overhead part shows against cur
function [2:0] partOp;
    input        first;
    input [13:0] rc;
    input [1:0]  ind;
    input [13:0] cur;
    integer      k;
    reg   [15:0] pm;
    reg   [13:0] df;
    begin
        partOp = OP_NONE;
        df = rc ^ cur;
        for (k = 4; k >= 0; k = k - 1) begin
            pm = patOf(k[2:0]);
            if (first && df[13:6] == pm[15:8]) begin
                partOp = k[2:0];
            end
            if (!first && {df[5:0], ind} == pm[7:0]) begin
                partOp = k[2:0];
            end
        end
    end
endfunction

// ----------------------------------------
// registers
// ----------------------------------------
reg [31:0]       ctrl_r;
reg [13:0]       txPrev_r;
reg [15:0]       crcErrCnt_r;
reg [2:0]        st_r;
reg [13:0]       huntCnt_r;
reg              huntInc_r;
reg              huntLsb_r;
reg [ADDR_W-1:0] awAddr_r;
reg              awHave_r;
reg [31:0]       wData_r;
reg [3:0]        wStrb_r;
reg              wHave_r;
integer          b;

wire       txEn  = ctrl_r[`GJC_CTRL_TXEN];
wire       rxEn  = ctrl_r[`GJC_CTRL_RXEN];
wire       gran1 = ctrl_r[`GJC_CTRL_GRAN1];
wire [2:0] ord   = ctrl_r[`GJC_CTRL_ORD +: 3];
wire [1:0] kind  = ctrl_r[`GJC_CTRL_KIND +: 2];
wire [6:0] ts    = ctrl_r[`GJC_CTRL_TS +: 7];

// ----------------------------------------
// container parameters
// ----------------------------------------
reg [15:0] mSize;
reg [15:0] wordBits;
reg [15:0] payWords;
reg [15:0] phaseMax;
reg [4:0]  cntWidth;

always @* begin
    case (ord)
        3'd0:    mSize = 16'h0001;
        3'd1:    mSize = 16'h0002;
        3'd2:    mSize = 16'h0008;
        3'd3:    mSize = 16'h0020;
        default: mSize = 16'h0050;
    endcase
    cntWidth = `GJC_CW_WIDE;
    if (kind == `GJC_KIND_LANE) begin
        wordBits = {2'b00, ts, 7'h00};
        payWords = `GJC_PAY_LANE;
        phaseMax = {5'h00, ts, 4'h0} - 16'h0001;
        cntWidth = `GJC_CW_LANE;
    end else if (kind == `GJC_KIND_TRIB) begin
        wordBits = {6'h00, ts, 3'h0};
        payWords = (ord == 3'd4) ? `GJC_PAY_T4 : `GJC_PAY_O0;
        phaseMax = (ts == 7'h00) ? 16'h0000 : {9'h000, ts - 7'h01};
    end else begin
        wordBits = {mSize[12:0], 3'h0};
        case (ord)
            3'd0:    payWords = `GJC_PAY_O0;
            3'd1:    payWords = `GJC_PAY_O1;
            3'd2:    payWords = `GJC_PAY_O2;
            3'd3:    payWords = `GJC_PAY_O3;
            default: payWords = `GJC_PAY_O4;
        endcase
        if (gran1) begin
            phaseMax = {mSize[12:0], 3'h0} - 16'h0001;
        end else begin
            phaseMax = mSize - 16'h0001;
        end
    end
end

// ----------------------------------------
// encoder
// ----------------------------------------
reg [13:0] encDelta;
reg [2:0]  encOp;
reg [15:0] encPat;
reg [15:0] encWord;

always @* begin
    encDelta = txCount - txPrev_r;
    case (encDelta)
        14'h0000: encOp = OP_Z;
        14'h0001: encOp = OP_P1;
        14'h3fff: encOp = OP_M1;
        14'h0002: encOp = OP_P2;
        14'h3ffe: encOp = OP_M2;
        default:  encOp = OP_BIG;
    endcase
    encPat = patOf(encOp);
    if (encOp == OP_BIG) begin
        encWord = {txCount, 2'b11};
    end else begin
        encWord = {txPrev_r ^ encPat[15:2], encPat[1:0]};
    end
end

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        txPrev_r                  <= 14'h0000;
        txCountOverheadFirstByte  <= 8'h00;
        txCountOverheadSecondByte <= 8'h00;
        txCountCrcByte            <= 8'h00;
        txOverheadValid           <= 1'b0;
    end else begin
        txOverheadValid <= txFrameStb & txEn;
        if (txFrameStb && txEn) begin
            txPrev_r                  <= txCount;
            txCountOverheadFirstByte  <= encWord[15:8];
            txCountOverheadSecondByte <= encWord[7:0];
            txCountCrcByte            <= crcRem24({encWord, 8'h00});
        end
    end
end

// ----------------------------------------
// decoder
// ----------------------------------------
wire [13:0] rc  = {rxCountOverheadFirstByte, rxCountOverheadSecondByte[7:2]};
wire [1:0]  ind = rxCountOverheadSecondByte[1:0];
wire        incrementIndicator = ind[1];
wire        decrementIndicator = ind[0];
wire        countLsb = rxCountOverheadSecondByte[2];
wire        crcOk = crcRem24({rxCountOverheadFirstByte, rxCountOverheadSecondByte,
                              rxCountCrcByte}) == 8'h00;

reg [2:0]  decSt;
reg [13:0] decCur;
reg        decAcc;
reg        decHold;
reg        found;
reg [2:0]  opA;
reg [2:0]  opB;
reg [13:0] base;
integer    q;
integer    p;

always @* begin
    decSt   = st_r;
    decCur  = rxCount;
    decAcc  = 1'b0;
    decHold = 1'b0;
    found   = 1'b0;
    opA     = OP_NONE;
    opB     = OP_NONE;
    base    = 14'h0000;
    q       = 0;
    p       = 0;
    if (crcOk && incrementIndicator == decrementIndicator) begin
        decCur = rc;
        decAcc = 1'b1;
        decSt  = ST_SYNC;
    end else if (crcOk && st_r == ST_SYNC) begin
        for (q = 0; q < 2; q = q + 1) begin
            opA = candOp(incrementIndicator, q[0]);
            if (!found && (rc ^ maskOf(opA)) == rxCount) begin
                found  = 1'b1;
                decCur = rxCount + stepOf(opA);
            end
        end
        decAcc  = found;
        decHold = !found;
        decSt   = found ? ST_SYNC : ST_PEND;
    end else if (crcOk) begin
        for (q = 0; q < 2; q = q + 1) begin
            opA  = candOp(incrementIndicator, q[0]);
            base = rc ^ maskOf(opA);
            for (p = 0; p < 2; p = p + 1) begin
                opB = candOp(huntInc_r, p[0] ^ huntLsb_r);
                if (!found && st_r == ST_PEND &&
                    (huntCnt_r ^ maskOf(opB)) + stepOf(opB) == base) begin
                    found  = 1'b1;
                    decCur = base + stepOf(opA);
                end
            end
        end
        decAcc  = found;
        decHold = !found;
        decSt   = found ? ST_SYNC : ST_PEND;
    end else if (st_r == ST_SYNC) begin
        opA = partOp(1'b1, rc, ind, rxCount);
        opB = partOp(1'b0, rc, ind, rxCount);
        if (opA != OP_NONE && (opB == OP_NONE || opB == opA)) begin
            decCur = rxCount + stepOf(opA);
            decAcc = 1'b1;
        end else if (opB != OP_NONE && opA == OP_NONE) begin
            decCur = rxCount + stepOf(opB);
            decAcc = 1'b1;
        end else begin
            decSt = ST_HUNT;
        end
    end else begin
        decSt = ST_HUNT;
    end
end

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        st_r         <= ST_HUNT;
        rxCount      <= 14'h0000;
        rxCountValid <= 1'b0;
        rxSync       <= 1'b0;
        rxCrcErr     <= 1'b0;
        huntCnt_r    <= 14'h0000;
        huntInc_r    <= 1'b0;
        huntLsb_r    <= 1'b0;
    end else begin
        rxCountValid <= 1'b0;
        rxCrcErr     <= 1'b0;
        if (!rxEn) begin
            st_r   <= ST_HUNT;
            rxSync <= 1'b0;
        end else if (rxFrameStb) begin
            case (st_r)
                ST_HUNT, ST_PEND, ST_SYNC: begin
                    st_r         <= decSt;
                    rxSync       <= (decSt == ST_SYNC);
                    rxCount      <= decCur;
                    rxCountValid <= decAcc;
                    rxCrcErr     <= !crcOk;
                end
                default: begin
                    st_r   <= ST_HUNT;
                    rxSync <= 1'b0;
                end
            endcase
            if (decHold) begin
                huntCnt_r <= rc;
                huntInc_r <= incrementIndicator;
                huntLsb_r <= countLsb;
            end
        end
    end
end

// ----------------------------------------
// register bus
// ----------------------------------------
reg [31:0] rdMux;
reg        rdBad;

always @* begin
    rdBad = 1'b0;
    case (s_axi_araddr)
        `GJC_OFS_CTRL:   rdMux = ctrl_r;
        `GJC_OFS_STAT:   rdMux = {2'b00, rxCount, 13'h0000, st_r};
        `GJC_OFS_TXCNT:  rdMux = {18'h00000, txPrev_r};
        `GJC_OFS_WORD:   rdMux = {16'h0000, wordBits};
        `GJC_OFS_PAYLD:  rdMux = {16'h0000, payWords};
        `GJC_OFS_PHASE:  rdMux = {11'h000, cntWidth, phaseMax};
        `GJC_OFS_CRCERR: rdMux = {16'h0000, crcErrCnt_r};
        default: begin
            rdMux = 32'h0000_0000;
            rdBad = 1'b1;
        end
    endcase
end

wire doWrite = awHave_r && wHave_r && !s_axi_bvalid;
wire crcEvt  = rxFrameStb && rxEn && !crcOk;

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= 2'b00;
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b0;
        s_axi_rresp   <= 2'b00;
        s_axi_rdata   <= 32'h0000_0000;
        awAddr_r      <= {ADDR_W{1'b0}};
        awHave_r      <= 1'b0;
        wData_r       <= 32'h0000_0000;
        wStrb_r       <= 4'h0;
        wHave_r       <= 1'b0;
        ctrl_r        <= `GJC_CTRL_RST;
        crcErrCnt_r   <= 16'h0000;
    end else begin
        s_axi_awready <= s_axi_awvalid && !s_axi_awready && !awHave_r;
        s_axi_wready  <= s_axi_wvalid && !s_axi_wready && !wHave_r;
        if (s_axi_awvalid && s_axi_awready) begin
            awAddr_r <= s_axi_awaddr;
            awHave_r <= 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
            wHave_r <= 1'b1;
        end
        if (crcEvt) begin
            crcErrCnt_r <= (doWrite && awAddr_r == `GJC_OFS_CRCERR) ?
                           16'h0001 : crcErrCnt_r + 16'h0001;
        end else if (doWrite && awAddr_r == `GJC_OFS_CRCERR) begin
            crcErrCnt_r <= 16'h0000;
        end
        if (doWrite) begin
            awHave_r     <= 1'b0;
            wHave_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'b00;
            if (awAddr_r == `GJC_OFS_CTRL) begin
                for (b = 0; b < 4; b = b + 1) begin
                    if (wStrb_r[b]) begin
                        ctrl_r[8*b +: 8] <= wData_r[8*b +: 8];
                    end
                end
            end else if (awAddr_r != `GJC_OFS_CRCERR) begin
                s_axi_bresp <= 2'b10;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
        s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdMux;
            s_axi_rresp  <= rdBad ? 2'b10 : 2'b00;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule

/* File: verilog/gjc_codec_regs.vh */
// Purpose: constants of the justification count codec
// Assumes: 32-bit register words, byte addresses
// Notes:   definitions only
`ifndef GJC_CODEC_REGS_VH
`define GJC_CODEC_REGS_VH

// ----
// register offsets
// ----
`define GJC_OFS_CTRL    8'h00
`define GJC_OFS_STAT    8'h04
`define GJC_OFS_TXCNT   8'h08
`define GJC_OFS_WORD    8'h0c
`define GJC_OFS_PAYLD   8'h10
`define GJC_OFS_PHASE   8'h14
`define GJC_OFS_CRCERR  8'h18

// ----
// control fields and reset value
// ----
`define GJC_CTRL_TXEN   0
`define GJC_CTRL_RXEN   1
`define GJC_CTRL_GRAN1  2
`define GJC_CTRL_ORD    4
`define GJC_CTRL_KIND   8
`define GJC_CTRL_TS     16
`define GJC_CTRL_RST    32'h0001_0003
`define GJC_KIND_CONT   2'h0
`define GJC_KIND_TRIB   2'h1
`define GJC_KIND_LANE   2'h2

// ----
// count coding
// ----
`define GJC_CRC_POLY    8'h0d
`define GJC_MASK_P1     14'h2aaa
`define GJC_MASK_M1     14'h1555
`define GJC_MASK_P2     14'h1999
`define GJC_MASK_M2     14'h2666
`define GJC_CW_WIDE     5'h0e
`define GJC_CW_LANE     5'h0a

// ----
// container figures
// ----
`define GJC_PAY_O0      16'h3b80
`define GJC_PAY_O1      16'h1dc0
`define GJC_PAY_O2      16'h0770
`define GJC_PAY_O3      16'h01dc
`define GJC_PAY_O4      16'h00be
`define GJC_PAY_T4      16'h3b60
`define GJC_PAY_LANE    16'h03b8

`endif

/* File: bench/gjc_codec_asserts.sv */
// Purpose: port level checks of the count codec
// Assumes: one clock, asynchronous active low reset
// Notes:   bound to gjc_codec at the foot
`timescale 1ns/1ns

module gjc_codec_chk (
    // clock and reset
    input wire        mclk,
    input wire        arst_n,
    // mapper side
    input wire        txFrameStb,
    input wire [13:0] txCount,
    input wire [7:0]  txCountOverheadFirstByte,
    input wire [7:0]  txCountOverheadSecondByte,
    input wire [7:0]  txCountCrcByte,
    input wire        txOverheadValid,
    // demapper side
    input wire        rxFrameStb,
    input wire [7:0]  rxCountOverheadFirstByte,
    input wire [7:0]  rxCountOverheadSecondByte,
    input wire [7:0]  rxCountCrcByte,
    input wire [13:0] rxCount,
    input wire        rxCountValid,
    input wire        rxSync,
    input wire        rxCrcErr
);
    function automatic logic [7:0] crc8(input logic [15:0] m);
        logic [7:0] c = 8'h00;
        for (int i = 15; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h0d : 8'h00);
        return c;
    endfunction

    wire [15:0] tW    = {txCountOverheadFirstByte, txCountOverheadSecondByte};
    wire [13:0] tC    = tW[15:2];
    wire [15:0] rW    = {rxCountOverheadFirstByte, rxCountOverheadSecondByte};
    wire [13:0] rC    = rW[15:2];
    wire        rGood = crc8(rW) == rxCountCrcByte;
    wire        rEq   = rW[1] == rW[0];
    wire        rDec1 = rxSync && rGood && rW[1:0] == 2'b01 && (rC ^ 14'h1555) == rxCount;

    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);

    AST_TX_CAUSE: assert property (txOverheadValid |-> $past(txFrameStb))
        else $error("overhead valid without frame strobe");
    AST_TX_CRC: assert property (txOverheadValid |-> crc8(tW) == txCountCrcByte)
        else $error("sent crc byte wrong");
    AST_TX_HOLD: assert property (!txFrameStb |=> $stable({tW, txCountCrcByte}))
        else $error("overhead bytes moved without strobe");
    AST_TX_PLAIN: assert property (txOverheadValid && tW[1] == tW[0] |-> tC == $past(txCount))
        else $error("plain count wrong");
    AST_TX_UP: assert property (txOverheadValid && tW[1:0] == 2'b10 |->
        (tC ^ 14'h2aaa) + 14'h1 == $past(txCount) || (tC ^ 14'h1999) + 14'h2 == $past(txCount))
        else $error("increment pattern wrong");
    AST_TX_DOWN: assert property (txOverheadValid && tW[1:0] == 2'b01 |->
        (tC ^ 14'h1555) - 14'h1 == $past(txCount) || (tC ^ 14'h2666) - 14'h2 == $past(txCount))
        else $error("decrement pattern wrong");
    AST_RX_CRCERR: assert property (rxCrcErr |-> $past(rxFrameStb) && !$past(rGood))
        else $error("crc error flag without bad frame");
    AST_RX_VALID: assert property (rxCountValid |-> $past(rxFrameStb))
        else $error("count valid without frame");
    AST_RX_ACCEPT: assert property (rxCountValid && $past(rGood) && $past(rEq) |->
        rxCount == $past(rC))
        else $error("plain count not accepted");
    AST_RX_DEC1: assert property (rxCountValid && $past(rDec1) |->
        rxCount == $past(rxCount) - 14'h1)
        else $error("minus one not applied");
    AST_RX_SYNC: assert property ($rose(rxSync) |-> $past(rxFrameStb) && $past(rGood))
        else $error("sync gained without good frame");

    cover property (rxCountValid && rxSync);
    cover property (rxCrcErr);
    cover property (txOverheadValid && tW[1:0] == 2'b11);
endmodule

bind gjc_codec gjc_codec_chk u_chk (.*);

/* File: bench/gjc_peer.sv */
// Purpose: far end mapper feeding overhead bytes to the demapper
// Assumes: one frame per sendStb pulse
// Notes:   corrupt[0] flips count bit 6, corrupt[1] count bit 0
`timescale 1ns/1ns

module gjc_peer (
    // clock and reset
    input  wire        mclk,
    input  wire        arst_n,
    // bench control
    input  wire        sendStb,
    input  wire [13:0] newCount,
    input  wire [1:0]  corrupt,
    // towards the demapper
    output reg         frameStb,
    output reg  [7:0]  jcFirst,
    output reg  [7:0]  jcSecond,
    output reg  [7:0]  jcCrc
);
    reg [13:0] prev_r;

    function automatic logic [7:0] crc8(input logic [15:0] m);
        logic [7:0] c = 8'h00;
        for (int i = 15; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h0d : 8'h00);
        return c;
    endfunction

    // pattern picked from the count difference
    function automatic logic [23:0] enc(input logic [13:0] p, input logic [13:0] n);
        logic [15:0] v;
        case (n - p)
            14'h0000: v = {n, 2'b00};
            14'h0001: v = {p ^ 14'h2aaa, 2'b10};
            14'h3fff: v = {p ^ 14'h1555, 2'b01};
            14'h0002: v = {p ^ 14'h1999, 2'b10};
            14'h3ffe: v = {p ^ 14'h2666, 2'b01};
            default:  v = {n, 2'b11};
        endcase
        return {v, crc8(v)};
    endfunction

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prev_r   <= 14'h0000;
            frameStb <= 1'b0;
            {jcFirst, jcSecond, jcCrc} <= 24'h000000;
        end else if (sendStb) begin
            frameStb <= 1'b1;
            prev_r   <= newCount;
            {jcFirst, jcSecond, jcCrc} <= enc(prev_r, newCount) ^
                {7'h00, corrupt[0], 5'h00, corrupt[1], 10'h000};
        end else begin
            frameStb <= 1'b0;
            // bytes outside a frame carry no meaning
            {jcFirst, jcSecond, jcCrc} <= ~{jcFirst, jcSecond, jcCrc};
        end
    end
endmodule

/* File: bench/gjc_codec_bench.sv */
// Purpose: register and frame level test of the count codec
// Assumes: 100 MHz mclk, answer timing as handed over
// Notes:   verdict printed by summarize
`timescale 1ns/1ns
`include "gjc_codec_regs.vh"

module gjc_codec_bench;
    reg         mclk, arst_n, awvalid, wvalid, bready, arvalid, rready, txStb, sendStb;
    reg  [7:0]  awaddr, araddr;
    reg  [31:0] wdata;
    reg  [13:0] txCnt, newCount, txPrev;
    reg  [1:0]  corrupt;
    wire        awready, wready, bvalid, arready, rvalid, rxStb, txValid, rxCntValid;
    wire        rxSync, rxCrcErr;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [7:0]  t1, t2, t3, r1, r2, r3;
    wire [13:0] rxCount;
    integer     failures = 0, num_checks = 0, cycles = 0;
    logic [13:0] txSeq [8] = '{14'h5, 14'h5, 14'h6, 14'h5, 14'h7, 14'h5, 14'h12c, 14'h12d};

    gjc_codec u_gjc_codec (
        .mclk(mclk), .arst_n(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .txFrameStb(txStb), .txCount(txCnt), .txCountOverheadFirstByte(t1),
        .txCountOverheadSecondByte(t2), .txCountCrcByte(t3), .txOverheadValid(txValid),
        .rxFrameStb(rxStb), .rxCountOverheadFirstByte(r1), .rxCountOverheadSecondByte(r2),
        .rxCountCrcByte(r3), .rxCount(rxCount), .rxCountValid(rxCntValid),
        .rxSync(rxSync), .rxCrcErr(rxCrcErr)
    );
    gjc_peer u_peer (
        .mclk(mclk), .arst_n(arst_n), .sendStb(sendStb), .newCount(newCount),
        .corrupt(corrupt), .frameStb(rxStb), .jcFirst(r1), .jcSecond(r2), .jcCrc(r3)
    );

    task automatic summarize;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string w, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask

    // ----
    // register bus
    // ----
    task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge mclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bready && bvalid) begin
                bready <= 1'b0;
                chk("bresp", er, bresp);
            end
        end while (bready);
    endtask

    task automatic axiRd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
                         input string w);
        @(posedge mclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rready && rvalid) begin
                rready <= 1'b0;
                chk(w, ed, rdata);
                chk("rresp", er, rresp);
            end
        end while (rready);
    endtask

    task automatic cfg(input logic [31:0] c, p, wd, ph);
        axiWr(`GJC_OFS_CTRL, c, 2'b00);
        axiRd(`GJC_OFS_PAYLD, p, 2'b00, "payload");
        axiRd(`GJC_OFS_WORD, wd, 2'b00, "word");
        axiRd(`GJC_OFS_PHASE, ph, 2'b00, "phase");
    endtask

    // ----
    // frames
    // ----
    task automatic txFrame(input logic [13:0] c);
        @(posedge mclk);
        txStb <= 1'b1;
        txCnt <= c;
        @(posedge mclk);
        txStb <= 1'b0;
        #1;
        chk("txValid", 1, txValid);
        chk("txBytes", u_peer.enc(txPrev, c), {t1, t2, t3});
        txPrev = c;
    endtask

    task automatic rxFrame(input logic [13:0] c, ec, input logic [1:0] bad, input logic s, er);
        @(posedge mclk);
        sendStb  <= 1'b1;
        newCount <= c;
        corrupt  <= bad;
        @(posedge mclk);
        sendStb <= 1'b0;
        @(posedge mclk);
        #1;
        chk("rxCount", ec, rxCount);
        chk("rxSync", s, rxSync);
        chk("rxValid", s, rxCntValid);
        chk("rxCrcErr", er, rxCrcErr);
    endtask

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            summarize;
        end
    end

    initial begin
        arst_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, txStb, sendStb} = 7'h00;
        {awaddr, araddr, wdata, txCnt, newCount, corrupt} = 78'h0;
        txPrev = 14'h0000;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        axiRd(`GJC_OFS_CTRL, 32'h0001_0003, 2'b00, "ctrl");
        axiRd(8'h1c, 32'h0, 2'b10, "unmapped");
        axiWr(8'h1c, 32'h1, 2'b10);
        axiWr(`GJC_OFS_PAYLD, 32'h1, 2'b10);
        cfg(32'h0001_0003, 32'h3b80, 32'h8, 32'h000e_0000);
        cfg(32'h0001_0013, 32'h1dc0, 32'h10, 32'h000e_0001);
        cfg(32'h0001_0023, 32'h0770, 32'h40, 32'h000e_0007);
        cfg(32'h0001_0033, 32'h01dc, 32'h100, 32'h000e_001f);
        cfg(32'h0001_0043, 32'h00be, 32'h280, 32'h000e_004f);
        cfg(32'h0001_0047, 32'h00be, 32'h280, 32'h000e_027f);
        cfg(32'h0003_0143, 32'h3b60, 32'h18, 32'h000e_0002);
        cfg(32'h0002_0203, 32'h03b8, 32'h100, 32'h000a_001f);
        axiWr(`GJC_OFS_CTRL, 32'h0001_0003, 2'b00);
        foreach (txSeq[i]) txFrame(txSeq[i]);
        axiRd(`GJC_OFS_TXCNT, 32'h12d, 2'b00, "txcnt");
        rxFrame(14'h64, 14'h64, 2'h0, 1'b1, 1'b0);
        rxFrame(14'h65, 14'h65, 2'h0, 1'b1, 1'b0);
        rxFrame(14'h64, 14'h64, 2'h0, 1'b1, 1'b0);
        rxFrame(14'h66, 14'h66, 2'h0, 1'b1, 1'b0);
        rxFrame(14'h64, 14'h64, 2'h0, 1'b1, 1'b0);
        rxFrame(14'h64, 14'h64, 2'h0, 1'b1, 1'b0);
        rxFrame(14'h64, 14'h64, 2'h1, 1'b1, 1'b1);
        rxFrame(14'h64, 14'h64, 2'h3, 1'b0, 1'b1);
        rxFrame(14'h65, 14'h64, 2'h0, 1'b0, 1'b0);
        rxFrame(14'h66, 14'h66, 2'h0, 1'b1, 1'b0);
        axiRd(`GJC_OFS_CRCERR, 32'h2, 2'b00, "crcerr");
        axiWr(`GJC_OFS_CRCERR, 32'h0, 2'b00);
        axiRd(`GJC_OFS_CRCERR, 32'h0, 2'b00, "crcerr");
        axiRd(`GJC_OFS_STAT, 32'h0066_0004, 2'b00, "stat");
        // both directions disabled: strobe ignored, sync dropped
        axiWr(`GJC_OFS_CTRL, 32'h0001_0000, 2'b00);
        @(posedge mclk);
        txStb <= 1'b1;
        @(posedge mclk);
        txStb <= 1'b0;
        #1;
        chk("txValid", 0, txValid);
        chk("rxSync", 0, rxSync);
        summarize;
    end
endmodule
